/* logic/ext_trig_defs.vh */
// Purpose: Shared constants of the external TTL trigger detector.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Register indices are word indices; byte address is four times the index.
`ifndef EXT_TRIG_DEFS_VH
`define EXT_TRIG_DEFS_VH

// =====================================================================
// Bus geometry
// =====================================================================
`define ADDR_W            18
`define DATA_W            32
`define IDX_W             16
`define IDX_MSB           17
`define IDX_LSB           2
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// =====================================================================
// Register indices (byte address = index * 4)
// =====================================================================
`define IDX_MODE          16'h9E3E
`define IDX_MAX_PW        16'hACA8
`define IDX_PW            16'hACB2
`define IDX_CTRL          16'hB000
`define IDX_STATUS        16'hB001
`define IDX_IRQ_STAT      16'hB002
`define IDX_IRQ_MASK      16'hB003
`define IDX_OR_MASK       16'hB004
`define IDX_TRIG_OUT_EN   16'hB005
`define IDX_AVAIL         16'hB006

// =====================================================================
// Trigger mode codes
// =====================================================================
`define MODE_NONE         32'h00000000
`define MODE_POS          32'h00000001
`define MODE_NEG          32'h00000002
`define MODE_BOTH         32'h00000004
`define MODE_HIGH         32'h00000008
`define MODE_LOW          32'h00000010
`define MODE_POS_STRETCH  32'h10000001
`define MODE_NEG_STRETCH  32'h10000002
`define MODE_PW_HIGH_LONG 32'h04000001
`define MODE_PW_HIGH_SHRT 32'h02000001
`define MODE_PW_LOW_LONG  32'h04000002
`define MODE_PW_LOW_SHRT  32'h02000002
`define AVAIL_BASE        32'h0600001F
`define AVAIL_STRETCH     32'h10000000
`define STRETCH_PRESENT   1'b1

// =====================================================================
// Fields, widths and reset values
// =====================================================================
`define PW_W              16
`define PW_MAX            16'hFFFF
`define PW_RESET          16'h0002
`define PW_ONE            16'h0001
`define OR_MASK_RESET     32'h00000000
`define MASK_EXT_BIT      1
`define CTRL_ARM_BIT      0
`define CTRL_DONE_BIT     1
`define STAT_ARMED_BIT    0
`define STAT_FIRED_BIT    1
`define STAT_LEVEL_BIT    2
`define IRQ_W             2
`define IRQ_TRIG_BIT      0
`define IRQ_DONE_BIT      1

`endif

/* logic/sync_2ff.v */
// Purpose: Two-flop synchroniser for levels entering the sample clock domain.
// Assumes: Inputs are levels; pulses shorter than one clock may be missed.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps

module sync_2ff
#(
	parameter WIDTH = 1
)
(
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] meta_q;  // Metastability stage

	// =================================================================
	// Two register stages
	// =================================================================
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= {WIDTH{1'b0}};
			dout   <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule

/* logic/short_pulse_catcher.v */
// Purpose: Catch input pulses shorter than one sample period.
// Assumes: Clears come from flip-flops of the sample clock domain.
// Notes:   A pulse arriving while its clear is high is lost.
`timescale 1ns/100ps

module short_pulse_catcher
(
	input  wire pin,
	input  wire clr_high,
	input  wire clr_low,
	output reg  high_seen,
	output reg  low_seen
);

	// =================================================================
	// Rising pin edge marks a HIGH pulse, held until cleared
	// =================================================================
	always @(posedge pin or posedge clr_high)
	begin
		if (clr_high)
			high_seen <= 1'b0;
		else
			high_seen <= 1'b1;
	end

	// =================================================================
	// Falling pin edge marks a LOW pulse, held until cleared
	// =================================================================
	always @(negedge pin or posedge clr_low)
	begin
		if (clr_low)
			low_seen <= 1'b0;
		else
			low_seen <= 1'b1;
	end

endmodule

/* logic/ext_trigger_detector.v */
// Purpose: External TTL trigger detector with AXI4-Lite registers.
// Assumes: Sample clock sys_clk; acquisition logic on the same clock.
// Notes:   One trigger per arming; pulse widths counted in sample periods.
// What this block does
// - Mode 1h fires on first rising edge.
// - After trigger, ignore input until done and rearmed.
// - Mode 8h fires on HIGH, even at start.
// - Mode 10h fires on LOW, even at start.
// - Mode 2h fires on first falling edge.
// - Mode 4h fires on first edge either way.
// - Mode 10000001h stretches short HIGH pulses.
// - Mode 10000002h stretches short LOW pulses.
// - Available-modes mask reports stretch support.
// - Mode 4000001h fires on HIGH longer than width.
// - Mode 2000001h fires on HIGH shorter than width.
// - Mode 4000002h fires on LOW longer than width.
// - Mode 2000002h fires on LOW shorter than width.
// - Width in samples, 2..65535, shared by modes.
// - Read-only register gives maximum width count.
// - External bit in OR mask gates trigger.
// - External mode forces connector to input.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ext_trig_defs.vh"

module ext_trigger_detector
(
	input  wire                 sys_clk,
	input  wire                 rst_b,
	input  wire                 ext_trig_pin,
	input  wire                 acq_arm,
	input  wire                 acq_done,
	input  wire                 int_trig,
	output reg                  trig_pulse,
	output reg                  trig_conn_out,
	output reg                  trig_conn_oe,
	output reg                  irq,
	input  wire [`ADDR_W-1:0]   awaddr,
	input  wire                 awvalid,
	output reg                  awready,
	input  wire [`DATA_W-1:0]   wdata,
	input  wire [3:0]           wstrb,
	input  wire                 wvalid,
	output reg                  wready,
	output reg  [1:0]           bresp,
	output reg                  bvalid,
	input  wire                 bready,
	input  wire [`ADDR_W-1:0]   araddr,
	input  wire                 arvalid,
	output reg                  arready,
	output reg  [`DATA_W-1:0]   rdata,
	output reg  [1:0]           rresp,
	output reg                  rvalid,
	input  wire                 rready
);

	// =================================================================
	// Local codes
	// =================================================================
	localparam ST_IDLE  = 3'b001;  // Waiting for arm
	localparam ST_ARMED = 3'b010;  // Evaluating the input
	localparam ST_FIRED = 3'b100;  // Waiting for recording to finish

	localparam K_NONE = 4'h0;
	localparam K_POS  = 4'h1;
	localparam K_NEG  = 4'h2;
	localparam K_BOTH = 4'h3;
	localparam K_HIGH = 4'h4;
	localparam K_LOW  = 4'h5;
	localparam K_PSTR = 4'h6;
	localparam K_NSTR = 4'h7;
	localparam K_HLNG = 4'h8;
	localparam K_HSHT = 4'h9;
	localparam K_LLNG = 4'hA;
	localparam K_LSHT = 4'hB;

	// =================================================================
	// Functions
	// =================================================================
	// Mode word to kind; unsupported stretch falls back to plain edge
	function [3:0] mode_kind;
		input [`DATA_W-1:0] m;
		begin
			case (m)
				`MODE_POS:          mode_kind = K_POS;
				`MODE_NEG:          mode_kind = K_NEG;
				`MODE_BOTH:         mode_kind = K_BOTH;
				`MODE_HIGH:         mode_kind = K_HIGH;
				`MODE_LOW:          mode_kind = K_LOW;
				`MODE_POS_STRETCH:  mode_kind = `STRETCH_PRESENT ? K_PSTR : K_POS;
				`MODE_NEG_STRETCH:  mode_kind = `STRETCH_PRESENT ? K_NSTR : K_NEG;
				`MODE_PW_HIGH_LONG: mode_kind = K_HLNG;
				`MODE_PW_HIGH_SHRT: mode_kind = K_HSHT;
				`MODE_PW_LOW_LONG:  mode_kind = K_LLNG;
				`MODE_PW_LOW_SHRT:  mode_kind = K_LSHT;
				default:            mode_kind = K_NONE;
			endcase
		end
	endfunction

	// True for any register index that answers
	function is_mapped;
		input [`IDX_W-1:0] idx;
		begin
			case (idx)
				`IDX_MODE, `IDX_MAX_PW, `IDX_PW, `IDX_CTRL, `IDX_STATUS,
				`IDX_IRQ_STAT, `IDX_IRQ_MASK, `IDX_OR_MASK, `IDX_TRIG_OUT_EN,
				`IDX_AVAIL: is_mapped = 1'b1;
				default:    is_mapped = 1'b0;
			endcase
		end
	endfunction

	// Byte-lane merge of a write into an old value
	function [`DATA_W-1:0] merge;
		input [`DATA_W-1:0] old;
		input [`DATA_W-1:0] nw;
		input [3:0]         be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// =================================================================
	// Reset release
	// =================================================================
	reg rst_meta_q;  // First reset stage
	reg rst_n;       // Released reset used everywhere

	// Assert at once, release after two clocks
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// =================================================================
	// Declarations
	// =================================================================
	reg  [2:0]           state_q;      // One-hot detector state
	reg  [`DATA_W-1:0]   mode_q;       // ext_trigger_mode
	reg  [`PW_W-1:0]     pw_q;         // ext_pulse_width
	reg  [`DATA_W-1:0]   or_mask_q;    // trigger_source_or_mask
	reg                  out_en_q;     // trigger_output_enable
	reg  [`IRQ_W-1:0]    irq_stat_q;   // Sticky events
	reg  [`IRQ_W-1:0]    irq_mask_q;   // Event enables
	reg  [`PW_W-1:0]     cnt_q;        // Pulse width counter
	reg                  run_q;        // Counter follows a qualified pulse
	reg                  prev_q;       // Input level one sample ago
	reg                  clr_hi_q;     // Clear for the HIGH catcher
	reg                  clr_lo_q;     // Clear for the LOW catcher
	reg  [`ADDR_W-1:0]   aw_addr_q;    // Held write address
	reg                  aw_have_q;    // Write address taken
	reg  [`DATA_W-1:0]   w_data_q;     // Held write data
	reg  [3:0]           w_strb_q;     // Held byte strobes
	reg                  w_have_q;     // Write data taken
	wire                 hi_raw;       // Catcher outputs, not yet synced
	wire                 lo_raw;
	wire [2:0]           synced;       // {low seen, high seen, pin level}
	wire                 lvl;
	wire [3:0]           kind;
	wire                 armed;
	wire                 rise;
	wire                 fall;
	wire                 act;          // Pulse polarity of width modes
	wire                 act_prev;
	wire                 pw_mode;
	wire                 lead;
	wire                 trail;
	wire                 do_wr;
	wire [`IDX_W-1:0]    wr_idx;
	wire                 sw_arm;
	wire                 sw_done;
	wire                 arm_req;
	wire                 done_req;
	reg                  hit;
	reg                  fire;
	reg  [`DATA_W-1:0]   rd_word;

	// =================================================================
	// Input capture
	// =================================================================
	// Async catchers for sub-sample pulses
	short_pulse_catcher u_catch
	(
		.pin       (ext_trig_pin),
		.clr_high  (clr_hi_q),
		.clr_low   (clr_lo_q),
		.high_seen (hi_raw),
		.low_seen  (lo_raw)
	);

	// Pin and catcher flags cross into the sample clock here
	sync_2ff #(.WIDTH(3)) u_sync
	(
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   ({lo_raw, hi_raw, ext_trig_pin}),
		.dout  (synced)
	);

	assign lvl      = synced[0];
	assign kind     = mode_kind(mode_q);
	assign armed    = state_q[1];
	assign rise     = lvl & ~prev_q;
	assign fall     = ~lvl & prev_q;
	assign pw_mode  = (kind == K_HLNG) | (kind == K_HSHT) | (kind == K_LLNG) | (kind == K_LSHT);
	assign act      = ((kind == K_HLNG) | (kind == K_HSHT)) ? lvl : ~lvl;
	assign act_prev = ((kind == K_HLNG) | (kind == K_HSHT)) ? prev_q : ~prev_q;
	assign lead     = act & ~act_prev;
	assign trail    = ~act & act_prev & run_q;

	// =================================================================
	// Trigger condition per mode
	// =================================================================
	always @*
	begin
		case (kind)
			K_POS:   hit = rise;
			K_NEG:   hit = fall;
			K_BOTH:  hit = rise | fall;
			K_HIGH:  hit = lvl;
			K_LOW:   hit = ~lvl;
			K_PSTR:  hit = rise | synced[1];
			K_NSTR:  hit = fall | synced[2];
			K_HLNG:  hit = trail & (cnt_q > pw_q);
			K_HSHT:  hit = trail & (cnt_q < pw_q);
			K_LLNG:  hit = trail & (cnt_q > pw_q);
			K_LSHT:  hit = trail & (cnt_q < pw_q);
			default: hit = 1'b0;
		endcase
		// Only armed, and only with the external source enabled
		fire = armed & hit & or_mask_q[`MASK_EXT_BIT];
	end

	// =================================================================
	// Arming state machine
	// =================================================================
	assign sw_arm   = do_wr & (wr_idx == `IDX_CTRL) & w_strb_q[0] & w_data_q[`CTRL_ARM_BIT];
	assign sw_done  = do_wr & (wr_idx == `IDX_CTRL) & w_strb_q[0] & w_data_q[`CTRL_DONE_BIT];
	assign arm_req  = acq_arm | sw_arm;
	assign done_req = acq_done | sw_done;

	// Rearming waits for the end of the recording
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (arm_req)
						state_q <= ST_ARMED;
				ST_ARMED:
					if (fire)
						state_q <= ST_FIRED;
				ST_FIRED:
					if (done_req)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// =================================================================
	// Width counter, edge history and catcher clears
	// =================================================================
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q    <= `PW_ONE;
			run_q    <= 1'b0;
			prev_q   <= 1'b0;
			clr_hi_q <= 1'b1;
			clr_lo_q <= 1'b1;
		end
		else
		begin
			prev_q <= lvl;
			// Catchers stay cleared unless armed; a seen flag clears itself
			clr_hi_q <= ~armed | synced[1];
			clr_lo_q <= ~armed | synced[2];
			if (!armed || !pw_mode || trail)
				run_q <= 1'b0;
			else if (lead)
				run_q <= 1'b1;
			// Saturates so very long pulses still count as long
			if (lead)
				cnt_q <= `PW_ONE;
			else if (act && run_q && cnt_q != `PW_MAX)
				cnt_q <= cnt_q + `PW_ONE;
		end
	end

	// =================================================================
	// Block outputs
	// =================================================================
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_pulse    <= 1'b0;
			trig_conn_out <= 1'b0;
			trig_conn_oe  <= 1'b0;
			irq           <= 1'b0;
		end
		else
		begin
			trig_pulse    <= fire;
			trig_conn_out <= int_trig;
			// Any external mode turns the connector into an input
			trig_conn_oe  <= out_en_q & (mode_q == `MODE_NONE);
			irq           <= |(irq_stat_q & irq_mask_q);
		end
	end

	// =================================================================
	// AXI4-Lite write channel
	// =================================================================
	assign do_wr  = aw_have_q & w_have_q & ~bvalid;
	assign wr_idx = aw_addr_q[`IDX_MSB:`IDX_LSB];

	// Address and data are taken in either order, answer follows both
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= {`ADDR_W{1'b0}};
			w_data_q  <= {`DATA_W{1'b0}};
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_addr_q <= awaddr;
				aw_have_q <= 1'b1;
				awready   <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				w_have_q <= 1'b1;
				wready   <= 1'b0;
			end
			if (do_wr)
			begin
				bvalid <= 1'b1;
				bresp  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (bvalid && bready)
			begin
				bvalid    <= 1'b0;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				awready   <= 1'b1;
				wready    <= 1'b1;
			end
		end
	end

	// =================================================================
	// Writable registers
	// =================================================================
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q     <= `MODE_NONE;
			pw_q       <= `PW_RESET;
			or_mask_q  <= `OR_MASK_RESET;
			out_en_q   <= 1'b0;
			irq_mask_q <= {`IRQ_W{1'b0}};
			irq_stat_q <= {`IRQ_W{1'b0}};
		end
		else
		begin
			if (do_wr && wr_idx == `IDX_MODE)
				mode_q <= merge(mode_q, w_data_q, w_strb_q);
			// Width is used as written; software keeps it in range
			if (do_wr && wr_idx == `IDX_PW)
				pw_q <= {w_strb_q[1] ? w_data_q[15:8] : pw_q[15:8], w_strb_q[0] ? w_data_q[7:0] : pw_q[7:0]};
			if (do_wr && wr_idx == `IDX_OR_MASK)
				or_mask_q <= merge(or_mask_q, w_data_q, w_strb_q);
			if (do_wr && wr_idx == `IDX_TRIG_OUT_EN && w_strb_q[0])
				out_en_q <= w_data_q[0];
			if (do_wr && wr_idx == `IDX_IRQ_MASK && w_strb_q[0])
				irq_mask_q <= w_data_q[`IRQ_W-1:0];
			// Write one clears; a new event in the same cycle wins
			irq_stat_q <= (irq_stat_q
				& ~((do_wr && wr_idx == `IDX_IRQ_STAT && w_strb_q[0]) ? w_data_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}}))
				| {state_q[2] & done_req, fire};
		end
	end

	// =================================================================
	// AXI4-Lite read channel
	// =================================================================
	always @*
	begin
		case (araddr[`IDX_MSB:`IDX_LSB])
			`IDX_MODE:        rd_word = mode_q;
			`IDX_MAX_PW:      rd_word = {16'h0000, `PW_MAX};
			`IDX_PW:          rd_word = {16'h0000, pw_q};
			`IDX_STATUS:      rd_word = {29'h00000000, lvl, state_q[2], armed};
			`IDX_IRQ_STAT:    rd_word = {30'h00000000, irq_stat_q};
			`IDX_IRQ_MASK:    rd_word = {30'h00000000, irq_mask_q};
			`IDX_OR_MASK:     rd_word = or_mask_q;
			`IDX_TRIG_OUT_EN: rd_word = {31'h00000000, out_en_q};
			`IDX_AVAIL:       rd_word = `AVAIL_BASE | (`STRETCH_PRESENT ? `AVAIL_STRETCH : 32'h00000000);
			default:          rd_word = 32'h00000000;
		endcase
	end

	// One read at a time; data one clock after the address is taken
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= is_mapped(araddr[`IDX_MSB:`IDX_LSB]) ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule

/* verification/ext_trigger_props.sv */
// Purpose: Port-level assertions for the trigger detector.
// Assumes: Bound to the top module; names match its ports.
// Notes:   Done is seen only through acq_done.
`timescale 1ns/100ps
// ==============================
// Checker
// ==============================
module ext_trigger_props
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        acq_done,
	input wire logic        trig_pulse,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata
);
	logic fired_q;	// Trigger given, no done since
	// Track trigger-to-done span
	always @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			fired_q <= 1'h0;
		else if (acq_done)
			fired_q <= 1'h0;
		else if (trig_pulse)
			fired_q <= 1'h1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_pulse_single; trig_pulse |=> !trig_pulse; endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("long trigger");
	property p_one_per_arm; trig_pulse |-> !fired_q; endproperty
	a_one_per_arm: assert property (p_one_per_arm) else $error("second trigger");
	property p_b_answer; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
	a_b_answer: assert property (p_b_answer) else $error("late bvalid");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_b_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
	a_b_done: assert property (p_b_done) else $error("write not closed");
	property p_r_answer; arvalid && arready |=> rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("late rvalid");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
	property p_r_busy; rvalid |-> !arready; endproperty
	a_r_busy: assert property (p_r_busy) else $error("read overlap");
endmodule

/* verification/ttl_source.sv */
// Purpose: Model of the external TTL trigger source.
// Assumes: Push-pull TTL level, never released.
// Notes:   Changes land 2 ns after a call, clear of edges.
`timescale 1ns/100ps
// ==============================
// Source model
// ==============================
module ttl_source
(
	output logic pin
);
	initial pin = 1'h0;	// Idle low at power-up
	// Settle to a level
	task drive(input logic v);
		#2 pin = v;
	endtask
	// One pulse of level v, ns long
	task pulse(input logic v, input int ns);
		#2 pin = v;
		#(ns) pin = ~v;
	endtask
endmodule

/* verification/ext_trigger_detector_tb.sv */
// Purpose: Self-checking bench of the trigger detector.
// Assumes: Bench is the AXI4-Lite master.
// Notes:   Width trials use 10 ns samples.
`timescale 1ns/100ps
`include "ext_trig_defs.vh"
// ==============================
// Bench top
// ==============================
module ext_trigger_detector_tb;
	logic               sys_clk = 0, rst_b = 0, acq_arm = 0, acq_done = 0, int_trig = 0;
	logic [`ADDR_W-1:0] awaddr = 0, araddr = 0;
	logic [31:0]        wdata = 0, rdata;
	logic [3:0]         wstrb = 0;
	logic [1:0]         bresp, rresp;
	logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic               awready, wready, bvalid, arready, rvalid, trig_pulse, trig_conn_out, trig_conn_oe, irq;
	wire                ext_trig_pin;	// From the source model
	int                 err_total = 0, n_tests = 0;
	always #5 sys_clk = ~sys_clk;
	ext_trigger_detector u_dut (.*);
	ttl_source u_src (.pin(ext_trig_pin));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	// Write; each channel released when taken
	task wr(input [15:0] i, input [31:0] d, input [1:0] e);
		@(posedge sys_clk);
		awaddr <= {i, 2'h0};
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		while (!bvalid);
		bready <= 1'h1;
		@(posedge sys_clk);
		chk("bresp", e, bresp);
		bready <= 1'h0;
	endtask
	task rd(input [15:0] i, input [31:0] e, input [1:0] er);
		@(posedge sys_clk);
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'h0;
		end
		while (!rvalid);
		rready <= 1'h1;
		@(posedge sys_clk);
		chk("rdata", e, rdata);
		chk("rresp", er, rresp);
		rready <= 1'h0;
	endtask
	task arm;
		@(posedge sys_clk);
		acq_arm <= 1'h1;
		@(posedge sys_clk);
		acq_arm <= 1'h0;
	endtask
	task done;
		@(posedge sys_clk);
		acq_done <= 1'h1;
		@(posedge sys_clk);
		acq_done <= 1'h0;
	endtask
	// Count trigger pulses over n cycles
	task hits(input int n, input int e);
		int c;
		c = 0;
		repeat (n)
		begin
			@(posedge sys_clk);
			if (trig_pulse === 1'h1) c++;
		end
		chk("trig_count", e, c);
	endtask
	task go(input [31:0] m, input logic lv);
		wr(`IDX_MODE, m, `RESP_OKAY);
		u_src.drive(lv);
		repeat (5) @(posedge sys_clk);
		arm();
	endtask
	// Force a trigger if none came, then close the recording
	task idle_again;
		wr(`IDX_MODE, `MODE_BOTH, `RESP_OKAY);
		u_src.drive(!ext_trig_pin);
		repeat (8) @(posedge sys_clk);
		done();
	endtask
	task t_regs;
		rd(`IDX_MODE, `MODE_NONE, `RESP_OKAY);
		rd(`IDX_MAX_PW, `PW_MAX, `RESP_OKAY);
		rd(`IDX_AVAIL, `AVAIL_BASE | `AVAIL_STRETCH, `RESP_OKAY);
		wr(16'h0000, 32'h5, `RESP_SLVERR);
		rd(16'h0000, 32'h0, `RESP_SLVERR);
		wr(`IDX_TRIG_OUT_EN, 32'h1, `RESP_OKAY);
		int_trig <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chk("oe", 1, trig_conn_oe);
		chk("conn_out", 1, trig_conn_out);
		wr(`IDX_MODE, `MODE_POS, `RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("oe_ext", 0, trig_conn_oe);
		int_trig <= 1'h0;
	endtask
	task t_mask;
		wr(`IDX_IRQ_MASK, 32'h1, `RESP_OKAY);
		go(`MODE_POS, 1'h0);
		fork
			u_src.pulse(1'h1, 100);
			hits(30, 0);
		join
		wr(`IDX_OR_MASK, 32'h1 << `MASK_EXT_BIT, `RESP_OKAY);
		fork
			u_src.pulse(1'h1, 100);
			hits(30, 1);
		join
		chk("irq_set", 1, irq);
		wr(`IDX_IRQ_STAT, 32'h3, `RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		chk("irq_clr", 0, irq);
		wr(`IDX_IRQ_MASK, 32'h0, `RESP_OKAY);
		done();
	endtask
	task t_edges;
		logic [31:0] m [3] = '{`MODE_POS, `MODE_NEG, `MODE_BOTH};
		foreach (m[i])
		begin
			go(m[i], 1'h0);
			fork
				u_src.pulse(1'h1, 100);
				hits(40, 1);
			join
			done();
		end
		chk("irq_masked", 0, irq);
		wr(`IDX_IRQ_MASK, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		chk("irq_unmasked", 1, irq);
		wr(`IDX_IRQ_STAT, 32'h3, `RESP_OKAY);
		wr(`IDX_IRQ_MASK, 32'h0, `RESP_OKAY);
	endtask
	task t_levels;
		go(`MODE_HIGH, 1'h1);
		hits(10, 1);
		done();
		go(`MODE_LOW, 1'h0);
		hits(10, 1);
		done();
		go(`MODE_HIGH, 1'h0);
		hits(10, 0);
		fork
			u_src.pulse(1'h1, 50);
			hits(20, 1);
		join
		done();
		// Arm by register this time; left armed for the width trials
		wr(`IDX_CTRL, 32'h1, `RESP_OKAY);
		rd(`IDX_STATUS, 32'h1, `RESP_OKAY);
	endtask
	// Pulses below, at and above the width of 5
	task t_width;
		logic [31:0] m [4] = '{`MODE_PW_HIGH_LONG, `MODE_PW_HIGH_SHRT, `MODE_PW_LOW_LONG, `MODE_PW_LOW_SHRT};
		int w [3] = '{3, 5, 8};
		wr(`IDX_PW, 32'h5, `RESP_OKAY);
		rd(`IDX_PW, 32'h5, `RESP_OKAY);
		foreach (m[i])
			foreach (w[j])
			begin
				go(m[i], m[i][1]);
				fork
					u_src.pulse(!m[i][1], w[j] * 10);
					hits(40, (m[i][26] && w[j] > 5) || (m[i][25] && w[j] < 5));
				join
				idle_again();
			end
	endtask
	task t_stretch;
		go(`MODE_POS_STRETCH, 1'h0);
		// Catcher clears lift only a cycle after arming
		repeat (2) @(posedge sys_clk);
		fork
			u_src.pulse(1'h1, 3);
			hits(20, 1);
		join
		idle_again();
		go(`MODE_NEG_STRETCH, 1'h1);
		repeat (2) @(posedge sys_clk);
		fork
			u_src.pulse(1'h0, 3);
			hits(20, 1);
		join
		idle_again();
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge sys_clk);
		t_regs();
		t_mask();
		t_edges();
		t_levels();
		t_width();
		t_stretch();
		report_and_stop();
	end
	// Run needs about 1300 cycles
	initial
	begin
		#200000;
		err_total++;
		report_and_stop();
	end
endmodule
bind ext_trigger_detector ext_trigger_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .acq_done(acq_done),
	.trig_pulse(trig_pulse), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .rdata(rdata));
